// ---- hdl/sdw_pkg.sv ----
// Purpose: Shared constants and types for the write burst datapath
// Assumes: Core clock at 20 MHz, link clock from the controller
// Notes:   Widths here fix the carrier structs used on the ports

package sdw_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int COL_W = 6;
  localparam int DQ_BITS = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int BEATS = 8;
  localparam int PAIRS = 4;
  localparam int ARR_ADDR_W = BANK_W + COL_W;

  // Address bit positions within a command word
  localparam int ADDR_BIT_AUTO_PRE = 10;
  localparam int ADDR_BIT_BURST_SEL = 12;

  // Burst field encodings of the first mode register
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_PER_CMD = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;

  // Last beat index of each burst kind
  localparam logic [2:0] LAST_BEAT_EIGHT = 3'h7;
  localparam logic [2:0] LAST_BEAT_CHOP = 3'h3;
  localparam logic [1:0] LAST_PAIR = 2'h3;

  // Reset values
  localparam logic [BANKS-1:0] BANK_OPEN_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CORE_PERIOD_NS = 50;
  localparam int WR_RECOVERY_NS = 15;
  // Least time: round up, never below one cycle
  localparam int WR_RECOVERY_RAW =
    (WR_RECOVERY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int WR_RECOVERY_CYC =
    (WR_RECOVERY_RAW < 1) ? 1 : WR_RECOVERY_RAW;
  localparam int REC_CNT_W = 8;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic burst_sel;
  } sdw_cmd_s;

  typedef struct packed {
    logic [2*LANES-1:0] write_mask_n;
    logic [2*DQ_BITS-1:0] data;
  } sdw_pair_s;

  typedef struct packed {
    logic [BEATS*LANES-1:0] write_mask_n;
    logic [BEATS*DQ_BITS-1:0] data;
  } sdw_burst_s;

  typedef struct packed {
    logic [1:0] burst_field;
    logic mask_enable;
    logic bus_inversion;
    logic crc_enable;
    logic dll_locked;
  } sdw_cfg_s;

  typedef enum {
    SDW_IDLE,
    SDW_WAIT_DATA,
    SDW_STORE,
    SDW_RECOVER
  } sdw_state_e;

endpackage

// ---- hdl/sdw_array.sv ----
// Purpose: Storage array with per-lane write enables
// Assumes: One write and one read port on the core clock
// Notes:   Reads never see the write lane enables

`timescale 1ns/10ps

module sdw_array #(
  parameter int ADDR_W = 9,
  parameter int LANES = 2,
  parameter int LANE_W = 8
) (
  input wire logic core_clk_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [LANES-1:0] wr_lane_en_in,
  input wire logic [LANES*LANE_W-1:0] wr_data_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [LANES*LANE_W-1:0] rd_data_out
);

  logic [LANES*LANE_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  // ---------------------------------------------------------------
  // Lane writes
  // ---------------------------------------------------------------
  // Disabled lanes keep their old contents
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge core_clk_in) begin
      if (wr_en_in && wr_lane_en_in[g]) begin
        mem_ff[wr_addr_in][g*LANE_W +: LANE_W] <=
          wr_data_in[g*LANE_W +: LANE_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Registered read, unaffected by any mask
  always_ff @(posedge core_clk_in) begin
    rd_data_out <= mem_ff[rd_addr_in];
  end

endmodule // sdw_array

// ---- hdl/sdw_write_burst_ctl.sv ----
// Purpose: Write command and burst handling inside the memory device
// Assumes: Controller frames data in four link clocks of beat pairs
// Notes:   Burst, precharge and mask rules are listed below

`timescale 1ns/10ps

module sdw_write_burst_ctl #(
  parameter int DEV_WIDTH = 8,
  parameter int WR_REC_CYC = sdw_pkg::WR_RECOVERY_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic cmd_valid_in,
  input wire sdw_pkg::sdw_cmd_s cmd_in,
  input wire logic activate_in,
  input wire logic [sdw_pkg::BANK_W-1:0] activate_bank_in,
  input wire sdw_pkg::sdw_cfg_s cfg_in,
  input wire logic link_valid_in,
  input wire sdw_pkg::sdw_pair_s link_pair_in,
  input wire logic [sdw_pkg::ARR_ADDR_W-1:0] rd_addr_in,
  output logic [sdw_pkg::DQ_BITS-1:0] rd_data_out,
  output logic [sdw_pkg::BANKS-1:0] bank_open_out,
  output logic precharge_start_out,
  output logic cmd_refused_out,
  output logic busy_out,
  output logic recovery_busy_out,
  output logic mask_active_out,
  output logic config_conflict_out,
  output logic crc_persistent_out
);

  import sdw_pkg::*;

  // Mask pin only exists on byte-wide and word-wide parts
  localparam logic HAS_MASK = (DEV_WIDTH == 8) || (DEV_WIDTH == 16);

  // ---------------------------------------------------------------
  // Burst length decode
  // ---------------------------------------------------------------
  // Reserved field value 11 is treated as a fixed eight-beat burst
  function automatic logic burst_is_eight(input logic [1:0] field,
                                          input logic sel);
    logic r;
    r = 1'b1;
    case (field)
      BURST_FIXED_EIGHT: r = 1'b1;
      BURST_PER_CMD: r = sel;
      BURST_FIXED_CHOP: r = 1'b0;
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Link domain: reset crossing
  // ---------------------------------------------------------------
  logic lrst_s1_ff;
  logic lrst_s2_ff;

  // Reset reaches the link side only while its clock runs
  always_ff @(posedge link_clk_in) begin
    lrst_s1_ff <= rst_in;
    lrst_s2_ff <= lrst_s1_ff;
  end

  // ---------------------------------------------------------------
  // Link domain: beat pair assembly
  // ---------------------------------------------------------------
  logic [1:0] pair_cnt_ff;
  logic [(PAIRS-1)*2*DQ_BITS-1:0] asm_data_ff;
  logic [(PAIRS-1)*2*LANES-1:0] asm_mask_ff;
  sdw_burst_s hold_ff;
  logic hold_tog_ff;

  // Pair count within a frame
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2_ff) begin
      pair_cnt_ff <= 2'h0;
    end else if (link_valid_in) begin
      pair_cnt_ff <= pair_cnt_ff + 2'h1;
    end
  end

  // First three pairs collect here, slot by pair index
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2_ff) begin
      asm_data_ff <= '0;
      asm_mask_ff <= '0;
    end else if (link_valid_in && (pair_cnt_ff != LAST_PAIR)) begin
      asm_data_ff[pair_cnt_ff*2*DQ_BITS +: 2*DQ_BITS] <=
        link_pair_in.data;
      asm_mask_ff[pair_cnt_ff*2*LANES +: 2*LANES] <=
        link_pair_in.write_mask_n;
    end
  end

  // Whole burst moves to a holding word on the fourth pair.
  // The word then stands four link clocks, long enough for the core.
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2_ff) begin
      hold_ff <= '0;
    end else if (link_valid_in && (pair_cnt_ff == LAST_PAIR)) begin
      hold_ff.data <= {link_pair_in.data, asm_data_ff};
      hold_ff.write_mask_n <= {link_pair_in.write_mask_n, asm_mask_ff};
    end
  end

  // Toggle marks each finished burst for the core side
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2_ff) begin
      hold_tog_ff <= 1'b0;
    end else if (link_valid_in && (pair_cnt_ff == LAST_PAIR)) begin
      hold_tog_ff <= ~hold_tog_ff;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: crossings
  // ---------------------------------------------------------------
  logic tog_s1_ff;
  logic tog_s2_ff;
  logic tog_s3_ff;
  sdw_cfg_s cfg_s1_ff;
  sdw_cfg_s cfg_s2_ff;
  logic burst_arrived;

  // Toggle synchroniser; edge seen between second and third stage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
    end else begin
      tog_s1_ff <= hold_tog_ff;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
    end
  end

  assign burst_arrived = tog_s2_ff ^ tog_s3_ff;

  // Mode pins are quasi-static levels, two stages each
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
    end else begin
      cfg_s1_ff <= cfg_in;
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: mode derived flags
  // ---------------------------------------------------------------
  logic mask_ok;

  // Inversion wins if both are set, so masking stays off
  assign mask_ok = HAS_MASK && cfg_s2_ff.mask_enable &&
                   !cfg_s2_ff.bus_inversion;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mask_active_out <= 1'b0;
      config_conflict_out <= 1'b0;
      crc_persistent_out <= 1'b0;
    end else begin
      mask_active_out <= mask_ok;
      config_conflict_out <= cfg_s2_ff.mask_enable &&
                             cfg_s2_ff.bus_inversion;
      crc_persistent_out <= cfg_s2_ff.crc_enable &&
                            cfg_s2_ff.mask_enable;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: command acceptance and sequencing
  // ---------------------------------------------------------------
  sdw_state_e state_ff;
  sdw_cmd_s pend_ff;
  logic pend_eight_ff;
  sdw_burst_s burst_ff;
  logic [2:0] beat_ff;
  logic [REC_CNT_W-1:0] rec_cnt_ff;
  logic cmd_take;
  logic last_beat;

  // Only one write in flight; unlocked loop or closed bank refuses
  assign cmd_take = cmd_valid_in && (state_ff == SDW_IDLE) &&
                    cfg_s2_ff.dll_locked &&
                    bank_open_out[cmd_in.bank];
  assign last_beat = (state_ff == SDW_STORE) &&
                     (beat_ff == (pend_eight_ff ? LAST_BEAT_EIGHT
                                                : LAST_BEAT_CHOP));

  // Main sequencer
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= SDW_IDLE;
    end else begin
      case (state_ff)
        SDW_IDLE: begin
          if (cmd_take) begin
            state_ff <= SDW_WAIT_DATA;
          end
        end
        SDW_WAIT_DATA: begin
          if (burst_arrived) begin
            state_ff <= SDW_STORE;
          end
        end
        SDW_STORE: begin
          if (last_beat) begin
            state_ff <= SDW_RECOVER;
          end
        end
        SDW_RECOVER: begin
          if (rec_cnt_ff == REC_CNT_W'(1)) begin
            state_ff <= SDW_IDLE;
          end
        end
        default: state_ff <= SDW_IDLE;
      endcase
    end
  end

  // Command latch and burst kind decided at the command
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pend_ff <= '0;
      pend_eight_ff <= 1'b1;
    end else if (cmd_take) begin
      pend_ff <= cmd_in;
      pend_eight_ff <= burst_is_eight(cfg_s2_ff.burst_field,
                                      cmd_in.burst_sel);
    end
  end

  // Capture the crossed burst; holding word is stable by now
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      burst_ff <= '0;
    end else if ((state_ff == SDW_WAIT_DATA) && burst_arrived) begin
      burst_ff <= hold_ff;
    end
  end

  // Beat index during the store phase
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      beat_ff <= 3'h0;
    end else if (state_ff == SDW_STORE) begin
      beat_ff <= beat_ff + 3'h1;
    end else begin
      beat_ff <= 3'h0;
    end
  end

  // Recovery counter starts on the edge after the final beat
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rec_cnt_ff <= '0;
    end else if (last_beat) begin
      rec_cnt_ff <= REC_CNT_W'(WR_REC_CYC);
    end else if (rec_cnt_ff != '0) begin
      rec_cnt_ff <= rec_cnt_ff - REC_CNT_W'(1);
    end
  end

  // Status outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cmd_refused_out <= 1'b0;
      busy_out <= 1'b0;
      recovery_busy_out <= 1'b0;
    end else begin
      cmd_refused_out <= cmd_valid_in && !cmd_take;
      busy_out <= (state_ff != SDW_IDLE) || cmd_take;
      recovery_busy_out <= last_beat ||
                           (rec_cnt_ff > REC_CNT_W'(1));
    end
  end

  // ---------------------------------------------------------------
  // Core domain: bank state
  // ---------------------------------------------------------------
  logic pre_now;

  assign pre_now = last_beat && pend_ff.auto_pre;

  // Activate beats a same-cycle auto precharge of the same bank
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      bank_open_out <= BANK_OPEN_RST;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (activate_in && (activate_bank_in == BANK_W'(b))) begin
          bank_open_out[b] <= 1'b1;
        end else if (pre_now && (pend_ff.bank == BANK_W'(b))) begin
          bank_open_out[b] <= 1'b0;
        end
      end
    end
  end

  // Plain writes leave the bank open; only auto precharge pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      precharge_start_out <= 1'b0;
    end else begin
      precharge_start_out <= pre_now;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: array writes
  // ---------------------------------------------------------------
  logic [LANES-1:0] beat_mask_n;
  logic [LANES-1:0] lane_en;
  logic [DQ_BITS-1:0] beat_data;
  logic [ARR_ADDR_W-1:0] wr_addr;
  logic [2:0] col_low;

  assign beat_mask_n = burst_ff.write_mask_n[beat_ff*LANES +: LANES];
  assign beat_data = burst_ff.data[beat_ff*DQ_BITS +: DQ_BITS];
  // Mask low drops the lane, mask high stores it
  assign lane_en = mask_ok ? beat_mask_n
                           : {LANES{1'b1}};
  // Beats wrap inside the aligned group of eight columns
  assign col_low = pend_ff.col[2:0] + beat_ff;
  assign wr_addr = {pend_ff.bank, pend_ff.col[COL_W-1:3], col_low};

  // Store phase stops after beat three for a chopped burst
  sdw_array #(
    .ADDR_W(ARR_ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .core_clk_in(core_clk_in),
    .wr_en_in(state_ff == SDW_STORE),
    .wr_addr_in(wr_addr),
    .wr_lane_en_in(lane_en),
    .wr_data_in(beat_data),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out)
  );

endmodule // sdw_write_burst_ctl

// ---- tb/sdw_write_burst_ctl_monitor.sv ----
// Purpose: Port checks on the write burst block, core domain
// Assumes: Synchronous active high reset
// Notes:   Config checks wait out the two-flop synchroniser
`timescale 1ns/10ps
module sdw_write_burst_ctl_monitor
  import sdw_pkg::*;
#(
  parameter int WR_REC_CYC = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire sdw_pkg::sdw_cmd_s cmd_in,
  input wire sdw_pkg::sdw_cfg_s cfg_in,
  input wire logic [sdw_pkg::BANKS-1:0] bank_open_out,
  input wire logic precharge_start_out,
  input wire logic cmd_refused_out,
  input wire logic busy_out,
  input wire logic recovery_busy_out,
  input wire logic mask_active_out,
  input wire logic config_conflict_out,
  input wire logic crc_persistent_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Recovery length; cleared while idle so the fall sees the count
  logic [7:0] rec_cnt_ff;
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !recovery_busy_out) begin
      rec_cnt_ff <= 8'h00;
    end else begin
      rec_cnt_ff <= rec_cnt_ff + 8'h01;
    end
  end
  a_take_sets_busy: assert property (
    cmd_valid_in ##1 !cmd_refused_out |-> busy_out)
    else $error("command taken without busy");
  a_busy_refuse: assert property (
    cmd_valid_in && busy_out |=> cmd_refused_out)
    else $error("command taken while busy");
  a_closed_refuse: assert property (
    cmd_valid_in && !busy_out && !bank_open_out[cmd_in.bank]
    |=> cmd_refused_out)
    else $error("command taken on closed bank");
  a_dll_refuse: assert property (
    cmd_valid_in && !cfg_in.dll_locked && !$past(cfg_in.dll_locked)
    && !$past(cfg_in.dll_locked, 2) && !$past(cfg_in.dll_locked, 3)
    |=> cmd_refused_out)
    else $error("command taken with loop unlocked");
  a_precharge_close: assert property (
    precharge_start_out |-> recovery_busy_out &&
    $countones(bank_open_out) < $countones($past(bank_open_out)))
    else $error("precharge without bank close");
  a_precharge_pulse: assert property (
    precharge_start_out |=> !precharge_start_out)
    else $error("precharge pulse too long");
  a_recovery_len: assert property (
    $fell(recovery_busy_out) |-> rec_cnt_ff == 8'(WR_REC_CYC))
    else $error("recovery length wrong");
  a_conflict_flag: assert property (
    $stable(cfg_in) [*4] |-> config_conflict_out ==
    (cfg_in.mask_enable && cfg_in.bus_inversion))
    else $error("conflict flag wrong");
  a_mask_active: assert property (
    $stable(cfg_in) [*4] |-> mask_active_out ==
    (cfg_in.mask_enable && !cfg_in.bus_inversion))
    else $error("mask active flag wrong");
  a_crc_mode: assert property (
    $stable(cfg_in) [*4] |-> crc_persistent_out ==
    (cfg_in.crc_enable && cfg_in.mask_enable))
    else $error("crc mode flag wrong");
  c_precharge: cover property (precharge_start_out);
  c_refused: cover property (cmd_refused_out);
  c_recover: cover property ($fell(recovery_busy_out));
endmodule // sdw_write_burst_ctl_monitor

bind sdw_write_burst_ctl sdw_write_burst_ctl_monitor #(
  .WR_REC_CYC(WR_REC_CYC)
) u_mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cfg_in(cfg_in),
  .bank_open_out(bank_open_out), .busy_out(busy_out),
  .precharge_start_out(precharge_start_out),
  .cmd_refused_out(cmd_refused_out),
  .recovery_busy_out(recovery_busy_out),
  .mask_active_out(mask_active_out),
  .config_conflict_out(config_conflict_out),
  .crc_persistent_out(crc_persistent_out)
);

// ---- tb/sdw_link_ctrl_model.sv ----
// Purpose: Controller side of the write data link
// Assumes: Link clock of 160 ns, frames of four beat pairs
// Notes:   Clock stands still between frames after reset
`timescale 1ns/10ps
module sdw_link_ctrl_model
  import sdw_pkg::*;
(
  input wire logic start_in,
  input wire sdw_pkg::sdw_burst_s burst_in,
  output logic link_clk_out,
  output logic link_valid_out,
  output sdw_pkg::sdw_pair_s link_pair_out,
  output logic idle_out
);
  // Free run through reset so the link side sees the release
  initial begin
    link_clk_out = 1'b0;
    link_valid_out = 1'b0;
    link_pair_out = '0;
    idle_out = 1'b0;
    #17;
    repeat (12) begin
      #80 link_clk_out = 1'b1;
      #80 link_clk_out = 1'b0;
    end
    idle_out = 1'b1;
  end
  // Pair k holds beats 2k and 2k+1, set up 40 ns before the rising edge
  always @(posedge start_in) begin
    idle_out = 1'b0;
    for (int k = 0; k < PAIRS; k++) begin
      #40 link_valid_out = 1'b1;
      link_pair_out = {burst_in.write_mask_n[4*k+:4],
        burst_in.data[32*k+:32]};
      #40 link_clk_out = 1'b1;
      #80 link_clk_out = 1'b0;
    end
    #40 link_valid_out = 1'b0;
    // Released lines must not keep showing the last beat
    link_pair_out = ~link_pair_out;
    idle_out = 1'b1;
  end
endmodule // sdw_link_ctrl_model

// ---- tb/sdw_write_burst_ctl_test.sv ----
// Purpose: Self-checking bench for the write burst block
// Assumes: Inputs change on the falling core clock edge
// Notes:   A shadow memory predicts every stored lane
`timescale 1ns/10ps
module sdw_write_burst_ctl_test;
  import sdw_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic activate_in = 1'b0;
  logic [BANK_W-1:0] activate_bank_in = '0;
  logic [ARR_ADDR_W-1:0] rd_addr_in = '0;
  sdw_cmd_s cmd_in = '0;
  sdw_cfg_s cfg_in = '0;
  sdw_burst_s burst = '0;
  logic start = 1'b0;
  logic link_clk, link_valid, idle;
  sdw_pair_s link_pair;
  logic [DQ_BITS-1:0] rd_data_out;
  logic [BANKS-1:0] bank_open_out;
  logic pre_pulse, refused, busy, rec_busy, mask_act, conflict, crc_p;
  logic [DQ_BITS-1:0] shadow [2**ARR_ADDR_W];
  logic [1:0] row_fld [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [5:0] row_col [7] = '{6'h08, 6'h0d, 6'h0a, 6'h0e, 6'h09, 6'h08,
    6'h0b};
  logic [6:0] row_bs = 7'h54;
  logic [6:0] row_ap = 7'h40;
  logic [6:0] row_men = 7'h7e;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  sdw_write_burst_ctl u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .activate_in(activate_in), .activate_bank_in(activate_bank_in),
    .cfg_in(cfg_in), .link_valid_in(link_valid), .link_pair_in(link_pair),
    .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
    .bank_open_out(bank_open_out), .precharge_start_out(pre_pulse),
    .cmd_refused_out(refused), .busy_out(busy),
    .recovery_busy_out(rec_busy), .mask_active_out(mask_act),
    .config_conflict_out(conflict), .crc_persistent_out(crc_p)
  );
  sdw_link_ctrl_model u_ctrl (
    .start_in(start), .burst_in(burst), .link_clk_out(link_clk),
    .link_valid_out(link_valid), .link_pair_out(link_pair),
    .idle_out(idle)
  );

  // --------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // --------------------------------------------------------------
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Refusal is a one-cycle pulse, so look in exactly that cycle
  task automatic send_cmd(input logic [5:0] col, input logic ap,
      input logic bs, input logic exp_ref);
    @(negedge core_clk_in);
    cmd_valid_in = 1'b1;
    cmd_in = {3'h1, col, ap, bs};
    @(negedge core_clk_in);
    chk(refused, exp_ref);
    cmd_valid_in = 1'b0;
  endtask
  // Config passes a synchroniser: let it settle before use
  task automatic set_cfg(input logic [1:0] fld, input logic men,
      input logic inv, input logic crc, input logic dll);
    @(negedge core_clk_in);
    cfg_in = {fld, men, inv, crc, dll};
    repeat (4) @(negedge core_clk_in);
  endtask
  task automatic do_write(input int r, input logic [5:0] col,
      input logic ap, input logic bs, input logic men);
    int nb;
    logic pre;
    logic rec;
    logic [ARR_ADDR_W-1:0] a;
    pre = 1'b0;
    rec = 1'b0;
    burst.write_mask_n = 16'h5a3c ^ 16'(r * 16'h0111);
    for (int b = 0; b < BEATS; b++) begin
      burst.data[16*b+:16] = {4'hc, 4'(r), 4'h3, 4'(b)};
    end
    nb = (row_fld[r] == BURST_FIXED_CHOP ||
      (row_fld[r] == BURST_PER_CMD && !bs)) ? 4 : 8;
    send_cmd(col, ap, bs, 1'b0);
    if (r == 2) begin
      send_cmd(col, ap, bs, 1'b1);
    end
    start = 1'b1;
    @(negedge core_clk_in);
    start = 1'b0;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
      @(negedge core_clk_in);
      pre = pre | pre_pulse;
      rec = rec | rec_busy;
    end
    chk(busy, 1'b0);
    chk(rec, 1'b1);
    chk(pre, ap);
    chk(bank_open_out, ap ? 8'h00 : 8'h02);
    for (int b = 0; b < nb; b++) begin
      a = {3'h1, col[5:3], 3'(col[2:0] + b)};
      for (int l = 0; l < LANES; l++) begin
        if (!men || burst.write_mask_n[2*b+l]) begin
          shadow[a][8*l+:8] = burst.data[16*b+8*l+:8];
        end
      end
    end
    for (int j = 0; j < 8; j++) begin
      @(negedge core_clk_in);
      rd_addr_in = {3'h1, col[5:3], 3'(j)};
      @(negedge core_clk_in);
      chk(rd_data_out, shadow[rd_addr_in]);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: flags, refusals, then every burst mode
  initial begin
    repeat (20) @(negedge core_clk_in);
    rst_in = 1'b0;
    @(negedge core_clk_in);
    chk({busy, bank_open_out, refused}, 10'h000);
    wait (idle === 1'b1);
    set_cfg(2'h0, 1'b1, 1'b0, 1'b1, 1'b1);
    chk({mask_act, conflict, crc_p}, 3'h5);
    set_cfg(2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    chk({mask_act, conflict, crc_p}, 3'h3);
    set_cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk({mask_act, conflict, crc_p}, 3'h0);
    send_cmd(6'h08, 1'b0, 1'b0, 1'b1);
    @(negedge core_clk_in);
    activate_in = 1'b1;
    activate_bank_in = 3'h1;
    @(negedge core_clk_in);
    activate_in = 1'b0;
    set_cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    send_cmd(6'h08, 1'b0, 1'b0, 1'b1);
    for (int r = 0; r < 7; r++) begin
      set_cfg(row_fld[r], row_men[r], 1'b0, 1'b0, 1'b1);
      do_write(r, row_col[r], row_ap[r], row_bs[r], row_men[r]);
    end
    send_cmd(6'h08, 1'b0, 1'b0, 1'b1);
    final_report();
  end
endmodule // sdw_write_burst_ctl_test
